// ==== rtl/iac_defs.vh ====
// register map, field positions and reset values of the two-wire controller
`ifndef IAC_DEFS_VH
`define IAC_DEFS_VH
`define IAC_A_SADDR 8'h00
`define IAC_A_DIV 8'h04
`define IAC_A_CTL 8'h08
`define IAC_A_STS 8'h0c
`define IAC_A_DATA 8'h10
`define IAC_A_ACTL 8'h14
`define IAC_RST_BYTE 8'h00
`define IAC_SADDR_MASK 8'hfe
`define IAC_ACTL_MASK 8'hc7
`define IAC_C_EN 7
`define IAC_C_IE 6
`define IAC_C_MST 5
`define IAC_C_TX 4
`define IAC_C_TRANSMIT_ACK_CONTROL 3
`define IAC_C_REPEAT_START_REQUEST 2
`define IAC_S_ARBITRATION_LOST 4
`define IAC_S_IRQF 1
`define IAC_A_GCEN 7
`define IAC_A_EXT 6
`define IAC_A_B10 2
`define IAC_A_B9 1
`define IAC_A_B8 0
`define IAC_TEN_PREFIX 5'h1e
`define IAC_GC_ADDR 8'h00
`define IAC_DIV_SHIFT 2
`define IAC_RESP_OKAY 2'h0
`define IAC_RESP_SLVERR 2'h2
`endif

// ==== rtl/iac_ctrl.v ====
// byte-oriented two-wire bus controller with AXI4-Lite register access
// Function
// - general call matches too when enabled
// - general call: slave receiver, addressed flag set
// - data register holds received address byte
// - general call ignored and unacknowledged when disabled
// - comes up disabled, never resets the chip
// - interrupt is flag AND enable
// - interrupt flag cleared by writing one
// - byte, address match, arbitration loss raise flag
// - transfer complete at ninth clock fall
// - addressed flag on own or general address
// - lost arbitration on transmit bit mismatch
// - lost arbitration on receiver acknowledge mismatch
// - lost arbitration when starting on busy bus
// - lost arbitration on repeat start as slave
// - lost arbitration on unrequested stop
// - lost arbitration bit cleared by writing one
// - bit rate from multiplier and divider field
// - address register bits 7:1, bit 0 zero
// - ten-bit first byte is 11110, bits, direction
`default_nettype none
`include "iac_defs.vh"
module iac_ctrl #(
   parameter AW = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire [AW-1:0] awaddr,
   input wire awvalid,
   output wire awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   output wire [1:0] bresp,
   output wire bvalid,
   input wire bready,
   input wire [AW-1:0] araddr,
   input wire arvalid,
   output wire arready,
   output wire [31:0] rdata,
   output wire [1:0] rresp,
   output wire rvalid,
   input wire rready,
   input wire scl_in,
   output wire scl_out,
   output wire scl_oe_n,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe_n,
   output wire irq
);
   localparam ST_IDLE = 3'd0;
   localparam ST_START = 3'd1;
   localparam ST_RUN = 3'd2;
   localparam ST_STOP1 = 3'd3;
   localparam ST_STOP2 = 3'd4;
   localparam ST_STOP3 = 3'd5;
   localparam ST_RS1 = 3'd6;
   localparam ST_RS2 = 3'd7;

   function reg_hit;
      input [AW-1:0] a;
      begin
         reg_hit = (a == `IAC_A_SADDR) || (a == `IAC_A_DIV) || (a == `IAC_A_CTL) ||
            (a == `IAC_A_STS) || (a == `IAC_A_DATA) || (a == `IAC_A_ACTL);
      end
   endfunction

   // half scl period = multiplier x divider, divider = 4 x (field + 1)
   function [15:0] scl_half;
      input [7:0] f;
      reg [1:0] sh;
      begin
         case (f[7:6])
            2'b01: sh = 2'd1;
            2'b10: sh = 2'd2;
            default: sh = 2'd0;
         endcase
         scl_half = ({10'h000, f[5:0]} + 16'h0001) << (`IAC_DIV_SHIFT + sh);
      end
   endfunction

   reg aw_ok_r, w_ok_r, ws_r, bvalid_r, rvalid_r;
   reg [AW-1:0] awa_r;
   reg [7:0] wd_r;
   reg [1:0] bresp_r, rresp_r;
   reg [31:0] rdata_r;
   reg [7:0] sa_r, div_r, actl_r, data_r, shift_r, rd_nxt;
   reg en_r, ie_r, tx_r, transmit_ack_control_r, master_r;
   reg tcf_r, busy_r, arbitration_lost_r, irqf_r, srw_r, received_ack_r;
   reg scl_p_r, sda_p_r, scl_low_r, sda_low_r;
   reg active_r, xmit_r, hold_r, slv_sel_r, ack_ok_r, ten1_r, ten_known_r;
   reg [1:0] addr_ph_r;
   reg [3:0] bitcnt_r;
   reg [2:0] mst_st_r;
   reg [15:0] cnt_r;

   assign awready = ce & ~aw_ok_r & ~bvalid_r;
   assign wready = ce & ~w_ok_r & ~bvalid_r;
   assign arready = ce & ~rvalid_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;
   assign irq = irqf_r & ie_r;
   // open drain: output fixed low, enable (active low) pulls the wire
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe_n = ~scl_low_r;
   assign sda_oe_n = ~sda_low_r;

   wire wr_go = aw_ok_r & w_ok_r & ~bvalid_r;
   wire wr_en = wr_go & ws_r & reg_hit(awa_r);
   wire rd_go = arvalid & arready;
   wire w_ctl = wr_en & (awa_r == `IAC_A_CTL);
   wire w_sts = wr_en & (awa_r == `IAC_A_STS);
   wire w_dat = wr_en & (awa_r == `IAC_A_DATA);
   wire r_dat = rd_go & (araddr == `IAC_A_DATA);
   wire resume = hold_r & (w_dat | r_dat);
   wire mst_on = w_ctl & wd_r[`IAC_C_MST] & wd_r[`IAC_C_EN] & ~master_r;
   wire mst_off = w_ctl & ~wd_r[`IAC_C_MST] & master_r;
   wire rs_req = w_ctl & wd_r[`IAC_C_REPEAT_START_REQUEST] & wd_r[`IAC_C_EN];

   wire scl_rise = scl_in & ~scl_p_r;
   wire scl_fall = ~scl_in & scl_p_r;
   wire start_det = scl_in & scl_p_r & sda_p_r & ~sda_in;
   wire stop_det = scl_in & scl_p_r & ~sda_p_r & sda_in;
   wire [7:0] rx_byte = {shift_r[6:0], sda_in};
   wire m_gc = actl_r[`IAC_A_GCEN] & (rx_byte == `IAC_GC_ADDR);
   wire m_7 = ~actl_r[`IAC_A_EXT] & (rx_byte[7:1] == sa_r[7:1]);
   wire m_t1 = actl_r[`IAC_A_EXT] & (rx_byte[7:3] == `IAC_TEN_PREFIX) &
      (rx_byte[2:1] == {actl_r[`IAC_A_B10], actl_r[`IAC_A_B9]});
   wire m_t2 = (rx_byte == {actl_r[`IAC_A_B8], sa_r[7:1]});
   wire adr_hit = (addr_ph_r == 2'd1) ? (m_gc | m_7 | (m_t1 & (~rx_byte[0] | ten_known_r))) :
      ((addr_ph_r == 2'd2) & m_t2);
   wire addr_eval = scl_rise & active_r & (bitcnt_r == 4'd7) & ~master_r & (addr_ph_r != 2'd0);
   wire engaged = master_r | slv_sel_r | ((addr_ph_r != 2'd0) & ack_ok_r);
   wire byte_done = en_r & active_r & scl_fall & (bitcnt_r == 4'd9) & engaged;
   // we release sda (a one) where the bus should agree with us
   wire drive_hi = master_r & ~sda_low_r & ((xmit_r & (bitcnt_r < 4'd8)) | (~xmit_r & (bitcnt_r == 4'd8)));
   wire arb_bit = scl_rise & active_r & drive_hi & ~sda_in;
   wire arb_busy = mst_on & busy_r;
   wire arb_rs = rs_req & ~master_r;
   wire arb_stop = stop_det & master_r & (mst_st_r != ST_STOP3);
   wire lost = en_r & (arb_bit | arb_stop) | arb_busy | arb_rs;
   wire xmit_nx = master_r ? tx_r : (slv_sel_r & srw_r);
   wire tick = (cnt_r >= scl_half(div_r) - 16'h0001);

   always @* begin
      case (araddr)
         `IAC_A_SADDR: rd_nxt = sa_r;
         `IAC_A_DIV: rd_nxt = div_r;
         `IAC_A_CTL: rd_nxt = {en_r, ie_r, master_r, tx_r, transmit_ack_control_r, 3'b000};
         `IAC_A_STS: rd_nxt = {tcf_r, slv_sel_r, busy_r, arbitration_lost_r, 1'b0, srw_r, irqf_r, received_ack_r};
         `IAC_A_DATA: rd_nxt = data_r;
         `IAC_A_ACTL: rd_nxt = actl_r;
         default: rd_nxt = 8'h00;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_r <= 1'b0;
         w_ok_r <= 1'b0;
         ws_r <= 1'b0;
         awa_r <= {AW{1'b0}};
         wd_r <= 8'h00;
         bvalid_r <= 1'b0;
         bresp_r <= `IAC_RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= `IAC_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
         sa_r <= `IAC_RST_BYTE;
         div_r <= `IAC_RST_BYTE;
         actl_r <= `IAC_RST_BYTE;
         data_r <= `IAC_RST_BYTE;
         shift_r <= `IAC_RST_BYTE;
         en_r <= 1'b0;
         ie_r <= 1'b0;
         tx_r <= 1'b0;
         transmit_ack_control_r <= 1'b0;
         master_r <= 1'b0;
         tcf_r <= 1'b0;
         busy_r <= 1'b0;
         arbitration_lost_r <= 1'b0;
         irqf_r <= 1'b0;
         srw_r <= 1'b0;
         received_ack_r <= 1'b0;
         scl_p_r <= 1'b1;
         sda_p_r <= 1'b1;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         active_r <= 1'b0;
         xmit_r <= 1'b0;
         hold_r <= 1'b0;
         slv_sel_r <= 1'b0;
         ack_ok_r <= 1'b0;
         ten1_r <= 1'b0;
         ten_known_r <= 1'b0;
         addr_ph_r <= 2'd0;
         bitcnt_r <= 4'd0;
         mst_st_r <= ST_IDLE;
         cnt_r <= 16'h0000;
      end else if (ce) begin
         scl_p_r <= scl_in;
         sda_p_r <= sda_in;
         if (awvalid & awready) begin
            aw_ok_r <= 1'b1;
            awa_r <= awaddr;
         end
         if (wvalid & wready) begin
            w_ok_r <= 1'b1;
            wd_r <= wdata[7:0];
            ws_r <= wstrb[0];
         end
         if (wr_go) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= reg_hit(awa_r) ? `IAC_RESP_OKAY : `IAC_RESP_SLVERR;
         end else if (bvalid_r & bready) begin
            bvalid_r <= 1'b0;
         end
         if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, rd_nxt};
            rresp_r <= reg_hit(araddr) ? `IAC_RESP_OKAY : `IAC_RESP_SLVERR;
         end else if (rvalid_r & rready) begin
            rvalid_r <= 1'b0;
         end
         if (wr_en & (awa_r == `IAC_A_SADDR))
            sa_r <= wd_r & `IAC_SADDR_MASK;
         if (wr_en & (awa_r == `IAC_A_DIV))
            div_r <= wd_r;
         if (wr_en & (awa_r == `IAC_A_ACTL))
            actl_r <= wd_r & `IAC_ACTL_MASK;
         if (w_dat)
            data_r <= wd_r;
         if (w_ctl) begin
            en_r <= wd_r[`IAC_C_EN];
            ie_r <= wd_r[`IAC_C_IE];
            tx_r <= wd_r[`IAC_C_TX];
            transmit_ack_control_r <= wd_r[`IAC_C_TRANSMIT_ACK_CONTROL];
         end
         if (start_det)
            busy_r <= 1'b1;
         else if (stop_det)
            busy_r <= 1'b0;
         // hardware set wins over a software clear in the same cycle
         if (byte_done)
            tcf_r <= 1'b1;
         else if (resume)
            tcf_r <= 1'b0;
         if (byte_done | lost)
            irqf_r <= 1'b1;
         else if (w_sts & wd_r[`IAC_S_IRQF])
            irqf_r <= 1'b0;
         if (lost)
            arbitration_lost_r <= 1'b1;
         else if (w_sts & wd_r[`IAC_S_ARBITRATION_LOST])
            arbitration_lost_r <= 1'b0;
         if (!en_r) begin
            master_r <= 1'b0;
            mst_st_r <= ST_IDLE;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            active_r <= 1'b0;
            hold_r <= 1'b0;
            slv_sel_r <= 1'b0;
            ack_ok_r <= 1'b0;
            ten_known_r <= 1'b0;
            addr_ph_r <= 2'd0;
         end else begin
            if (start_det) begin
               active_r <= 1'b1;
               bitcnt_r <= 4'd0;
               addr_ph_r <= 2'd1;
               ack_ok_r <= 1'b0;
               hold_r <= 1'b0;
               if (!master_r) begin
                  xmit_r <= 1'b0;
                  slv_sel_r <= 1'b0;
                  sda_low_r <= 1'b0;
                  scl_low_r <= 1'b0;
               end
            end else if (stop_det) begin
               active_r <= 1'b0;
               addr_ph_r <= 2'd0;
               slv_sel_r <= 1'b0;
               ack_ok_r <= 1'b0;
               ten_known_r <= 1'b0;
               hold_r <= 1'b0;
            end else if (active_r & scl_rise) begin
               bitcnt_r <= bitcnt_r + 4'd1;
               if (bitcnt_r < 4'd8 && !xmit_r)
                  shift_r <= rx_byte;
               if (bitcnt_r == 4'd7 && !xmit_r)
                  data_r <= rx_byte;
               if (addr_eval) begin
                  ack_ok_r <= adr_hit;
                  ten1_r <= m_t1 & ~rx_byte[0];
                  if (addr_ph_r == 2'd1)
                     srw_r <= rx_byte[0] & ~m_gc;
               end
               if (bitcnt_r == 4'd8 && xmit_r) begin
                  received_ack_r <= sda_in;
                  if (!master_r && sda_in)
                     slv_sel_r <= 1'b0;
               end
            end else if (active_r & scl_fall) begin
               if (bitcnt_r == 4'd9) begin
                  bitcnt_r <= 4'd0;
                  sda_low_r <= 1'b0;
                  hold_r <= engaged;
                  ack_ok_r <= 1'b0;
                  if (engaged && !master_r)
                     scl_low_r <= 1'b1;
                  if (addr_ph_r != 2'd0 && !master_r) begin
                     slv_sel_r <= ack_ok_r;
                     addr_ph_r <= ((addr_ph_r == 2'd1) & ten1_r & ack_ok_r) ? 2'd2 : 2'd0;
                     if (addr_ph_r == 2'd2 && ack_ok_r)
                        ten_known_r <= 1'b1;
                  end else begin
                     addr_ph_r <= 2'd0;
                  end
               end else if (bitcnt_r == 4'd8) begin
                  if (xmit_r)
                     sda_low_r <= 1'b0;
                  else if (addr_ph_r != 2'd0 && !master_r)
                     sda_low_r <= ack_ok_r;
                  else
                     sda_low_r <= engaged & ~transmit_ack_control_r;
               end else if (xmit_r) begin
                  shift_r <= shift_r << 1;
                  sda_low_r <= ~shift_r[6];
               end
            end
            if (resume) begin
               hold_r <= 1'b0;
               xmit_r <= xmit_nx;
               if (!master_r)
                  scl_low_r <= 1'b0;
               if (w_dat) begin
                  shift_r <= wd_r;
                  sda_low_r <= xmit_nx & ~wd_r[7];
               end
            end
            // master clock and start, stop, repeat-start sequencing
            case (mst_st_r)
               ST_IDLE: begin
                  cnt_r <= 16'h0000;
                  if (mst_on && !busy_r) begin
                     master_r <= 1'b1;
                     mst_st_r <= ST_START;
                  end
               end
               ST_START: begin
                  sda_low_r <= 1'b1;
                  cnt_r <= tick ? 16'h0000 : cnt_r + 16'h0001;
                  if (tick) begin
                     scl_low_r <= 1'b1;
                     hold_r <= 1'b1;
                     mst_st_r <= ST_RUN;
                  end
               end
               ST_RUN: begin
                  if (mst_off) begin
                     mst_st_r <= ST_STOP1;
                     cnt_r <= 16'h0000;
                  end else if (rs_req) begin
                     mst_st_r <= ST_RS1;
                     cnt_r <= 16'h0000;
                  end else if (scl_low_r) begin
                     if (hold_r)
                        cnt_r <= 16'h0000;
                     else
                        cnt_r <= tick ? 16'h0000 : cnt_r + 16'h0001;
                     if (!hold_r && tick)
                        scl_low_r <= 1'b0;
                  end else begin
                     // a slave stretching scl keeps the high phase from counting
                     cnt_r <= (!scl_in || tick) ? 16'h0000 : cnt_r + 16'h0001;
                     if (scl_in && tick)
                        scl_low_r <= 1'b1;
                  end
               end
               ST_STOP1: begin
                  scl_low_r <= 1'b1;
                  sda_low_r <= 1'b1;
                  cnt_r <= tick ? 16'h0000 : cnt_r + 16'h0001;
                  if (tick)
                     mst_st_r <= ST_STOP2;
               end
               ST_STOP2: begin
                  scl_low_r <= 1'b0;
                  cnt_r <= (!scl_in || tick) ? 16'h0000 : cnt_r + 16'h0001;
                  if (scl_in && tick) begin
                     sda_low_r <= 1'b0;
                     mst_st_r <= ST_STOP3;
                  end
               end
               ST_STOP3: begin
                  if (stop_det) begin
                     master_r <= 1'b0;
                     mst_st_r <= ST_IDLE;
                  end
               end
               ST_RS1: begin
                  sda_low_r <= 1'b0;
                  cnt_r <= tick ? 16'h0000 : cnt_r + 16'h0001;
                  if (tick)
                     mst_st_r <= ST_RS2;
               end
               ST_RS2: begin
                  scl_low_r <= 1'b0;
                  cnt_r <= (!scl_in || tick) ? 16'h0000 : cnt_r + 16'h0001;
                  if (scl_in && tick)
                     mst_st_r <= ST_START;
               end
               default: mst_st_r <= ST_IDLE;
            endcase
            // a losing master drops to slave receive without a stop
            if (lost && master_r) begin
               master_r <= 1'b0;
               mst_st_r <= ST_IDLE;
               xmit_r <= 1'b0;
               sda_low_r <= 1'b0;
               scl_low_r <= 1'b0;
               hold_r <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/iac_properties.sv ====
// concurrent checks on the register bus and pins of the two-wire controller
`default_nettype none
module iac_properties #(
   parameter AW = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [AW-1:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [AW-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_rd_take;
      arvalid && arready;
   endsequence
   // reset must leave the block silent: no interrupt and both lines released
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn && ce |=> !irq && scl_oe_n && sda_oe_n)
      else $error("outputs not quiet after reset");
   a_wr_answer: assert property (s_wr_take |=> !bvalid ##1 bvalid)
      else $error("write answer latency wrong");
   a_wr_stand: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped early");
   a_rd_answer: assert property (s_rd_take |=> rvalid)
      else $error("read answer latency wrong");
   a_rd_stand: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped early");
   a_addr_lsb_zero: assert property (s_rd_take and araddr == 8'h00 |=> rdata[31:8] == 24'h0 && !rdata[0])
      else $error("slave address bit 0 not zero");
   a_unmapped_read: assert property (s_rd_take and araddr > 8'h14 |=> rresp == 2'h2 && rdata == 32'h0)
      else $error("unmapped read not refused");
   // a falling interrupt can only come from a register write taking effect
   a_irq_by_write: assert property ($fell(irq) |-> $rose(bvalid))
      else $error("interrupt dropped without a write");
endmodule
bind iac_ctrl iac_properties #(.AW(AW)) i_props (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
   .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
   .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
   .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .scl_in(scl_in), .scl_out(scl_out),
   .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
`default_nettype wire

// ==== verification/iac_bus_model.sv ====
// far-side bus master model: start, stop and bytes on the wired-and lines
`default_nettype none
module iac_bus_model (
   input wire logic aclk,
   input wire logic scl,
   input wire logic sda,
   output logic m_scl,
   output logic m_sda
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 40;
   int stuck = 0;
   initial begin
      m_scl = 1'b1;
      m_sda = 1'b1;
   end
   task automatic pause();
      repeat (HALF) @(posedge aclk);
   endtask
   // a slave may stretch the low phase, so the high phase starts once the wire is seen high
   task automatic rise();
      int n;
      m_scl <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (scl !== 1'b1 && n < 4000);
      if (n >= 4000) stuck++;
      pause();
   endtask
   task automatic start();
      m_sda <= 1'b0;
      pause();
      m_scl <= 1'b0;
      pause();
   endtask
   // data changes only while the clock is low; the ninth slot is released for the acknowledge
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 8; i >= 0; i--) begin
         m_sda <= (i == 0) ? 1'b1 : b[i-1];
         pause();
         rise();
         ack = sda;
         m_scl <= 1'b0;
         pause();
      end
   endtask
   task automatic stop();
      m_sda <= 1'b0;
      pause();
      rise();
      m_sda <= 1'b1;
      pause();
   endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// bench for the two-wire controller: register table, addressing, flags, arbitration
`default_nettype none
`include "iac_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} iac_row_t;
   iac_row_t rows [7] = '{'{`IAC_A_SADDR, 8'hff, 8'hfe, 2'h0}, '{`IAC_A_DIV, 8'hff, 8'hff, 2'h0},
      '{`IAC_A_CTL, 8'h58, 8'h58, 2'h0}, '{`IAC_A_STS, 8'hff, 8'h00, 2'h0}, '{`IAC_A_ACTL, 8'hff, 8'hc7, 2'h0},
      '{`IAC_A_ACTL, 8'h00, 8'h00, 2'h0}, '{8'h18, 8'h5a, 8'h00, `IAC_RESP_SLVERR}};
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, jam = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ack;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, resp;
   logic awready, wready, bvalid, arready, rvalid, scl_out, scl_oe_n, sda_out, sda_oe_n, irq;
   logic m_scl, m_sda, scl_w, sda_w;
   int error_cnt = 0, checks = 0;
   always #2 aclk = ~aclk;
   assign scl_w = scl_oe_n & m_scl;
   assign sda_w = sda_oe_n & m_sda & ~jam;
   iac_bus_model i_bus (.aclk(aclk), .scl(scl_w), .sda(sda_w), .m_scl(m_scl), .m_sda(m_sda));
   iac_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic hang();
      error_cnt++;
      $display("[FAIL] t=%0t wait ran out", $time);
      report_and_stop();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 200);
      if (n >= 200) hang();
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 200);
      if (n >= 200) hang();
      q = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      rd(a);
      chk(q & {24'h0, m}, {24'h0, e});
   endtask
   // status is polled over the bus since bus timing depends on the far side
   task automatic poll(input logic [7:0] m);
      int n;
      n = 0;
      do begin
         rd(`IAC_A_STS);
         n++;
      end while ((q[7:0] & m) == 8'h00 && n < 50);
      if (n >= 50) hang();
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rdchk(8'(i * 4), 8'hff, 8'h00);
      end
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk(resp, rows[i].r);
         rdchk(rows[i].a, 8'hff, rows[i].e);
         chk(resp, rows[i].r);
      end
      $display("register table: done");
      wr(`IAC_A_CTL, 8'h80);
      i_bus.start();
      i_bus.send(8'h00, ack);
      chk(ack, 1'b1);
      rdchk(`IAC_A_STS, 8'h62, 8'h20);
      i_bus.stop();
      rdchk(`IAC_A_STS, 8'h20, 8'h00);
      $display("general call disabled: done");
      wr(`IAC_A_ACTL, 8'h80);
      wr(`IAC_A_CTL, 8'hc0);
      i_bus.start();
      i_bus.send(8'h00, ack);
      chk(ack, 1'b0);
      rdchk(`IAC_A_STS, 8'he6, 8'he2);
      chk(irq, 1'b1);
      wr(`IAC_A_CTL, 8'h80);
      chk(irq, 1'b0);
      wr(`IAC_A_CTL, 8'hc0);
      chk(irq, 1'b1);
      rdchk(`IAC_A_DATA, 8'hff, `IAC_GC_ADDR);
      wr(`IAC_A_STS, 8'h02);
      chk(irq, 1'b0);
      i_bus.stop();
      $display("general call enabled: done");
      wr(`IAC_A_SADDR, 8'h54);
      i_bus.start();
      i_bus.send(8'h54, ack);
      chk(ack, 1'b0);
      rdchk(`IAC_A_STS, 8'h46, 8'h42);
      rdchk(`IAC_A_DATA, 8'hff, 8'h54);
      wr(`IAC_A_STS, 8'h02);
      i_bus.stop();
      $display("own address: done");
      wr(`IAC_A_ACTL, 8'h45);
      i_bus.start();
      i_bus.send(8'hf4, ack);
      chk(ack, 1'b0);
      rdchk(`IAC_A_STS, 8'h40, 8'h40);
      rd(`IAC_A_DATA);
      i_bus.send(8'haa, ack);
      chk(ack, 1'b0);
      rdchk(`IAC_A_STS, 8'h40, 8'h40);
      rd(`IAC_A_DATA);
      wr(`IAC_A_STS, 8'h02);
      i_bus.stop();
      $display("ten-bit address: done");
      i_bus.start();
      rdchk(`IAC_A_STS, 8'h20, 8'h20);
      wr(`IAC_A_CTL, 8'ha0);
      rdchk(`IAC_A_STS, 8'h12, 8'h12);
      rdchk(`IAC_A_STS, 8'h10, 8'h10);
      wr(`IAC_A_STS, 8'h12);
      rdchk(`IAC_A_STS, 8'h12, 8'h00);
      wr(`IAC_A_CTL, 8'h84);
      rdchk(`IAC_A_STS, 8'h10, 8'h10);
      wr(`IAC_A_STS, 8'h12);
      i_bus.stop();
      $display("busy bus and repeat start as slave: done");
      wr(`IAC_A_DIV, 8'h00);
      wr(`IAC_A_CTL, 8'hb0);
      poll(8'h20);
      jam <= 1'b1;
      wr(`IAC_A_DATA, 8'h80);
      poll(8'h10);
      chk(q & 32'h12, 32'h12);
      rdchk(`IAC_A_CTL, 8'h20, 8'h00);
      chk({scl_oe_n, sda_oe_n}, 2'h3);
      jam <= 1'b0;
      $display("lost arbitration while sending: done");
      wr(`IAC_A_CTL, 8'hb0);
      poll(8'h20);
      wr(`IAC_A_DATA, 8'h55);
      // nobody answers the byte, so the acknowledge slot reads back high
      poll(8'h80);
      chk(q & 32'h81, 32'h81);
      wr(`IAC_A_CTL, 8'h90);
      repeat (20) @(posedge aclk);
      rdchk(`IAC_A_STS, 8'h20, 8'h00);
      $display("master send without acknowledge: done");
      wr(`IAC_A_CTL, 8'hc0);
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rdchk(`IAC_A_CTL, 8'hff, 8'h00);
      chk(irq, 1'b0);
      // with the clock enable low every bus request must be refused
      ce <= 1'b0;
      repeat (2) @(posedge aclk);
      chk({awready, wready, arready}, 32'h0);
      ce <= 1'b1;
      chk(i_bus.stuck, 32'h0);
      $display("second reset: done");
      report_and_stop();
   end
endmodule
`default_nettype wire
